// File: abz_field_pkg.sv
package abz_field_pkg;

  // clock and ABZ update rate, in MHz
  localparam int CLK_MHZ        = 25;
  localparam int ABZ_UPDATE_MHZ = 16;

  // register offsets, SPI 5-bit address space
  localparam logic [4:0] ADDR_PULSE_LOW_INDEX = 5'h04;
  localparam logic [4:0] ADDR_PULSE_HIGH      = 5'h05;
  localparam logic [4:0] ADDR_FIELD_THRESH    = 5'h06;
  localparam logic [4:0] ADDR_FILTER_WINDOW   = 5'h0E;
  localparam logic [4:0] ADDR_INCR_HYST       = 5'h10;
  localparam logic [4:0] ADDR_ALARM_STATUS    = 5'h1B;

  // reset values: pulse count code 1023, index shape 0000
  localparam logic [7:0] RST_PULSE_LOW_INDEX = 8'hC0;
  localparam logic [7:0] RST_PULSE_HIGH      = 8'hFF;
  localparam logic [7:0] RST_FIELD_THRESH    = 8'h1C;
  localparam logic [7:0] RST_FILTER_WINDOW   = 8'h77;
  localparam logic [7:0] RST_INCR_HYST       = 8'h9C;

  // field positions
  localparam int PCL_POS    = 6;   // pulse count code bits 1:0 in reg 0x4
  localparam int SHAPE_POS  = 0;   // index shape select bits 3:0 in reg 0x4
  localparam int LOWTH_POS  = 5;   // low field threshold bits 7:5
  localparam int HIGHTH_POS = 2;   // high field threshold bits 4:2
  localparam int FHIGH_POS  = 7;   // status bit of high field flag
  localparam int FLOW_POS   = 6;   // status bit of low field flag

  // SPI frame commands
  localparam logic [2:0] CMD_READ  = 3'b010;
  localparam logic [2:0] CMD_WRITE = 3'b100;
  localparam logic [4:0] SPI_FRAME_BITS = 5'd16;

  // filter window codes: first code, spacing, number of codes
  localparam logic [7:0] FW_FIRST_CODE = 8'd51;
  localparam logic [7:0] FW_CODE_STEP  = 8'd17;
  localparam logic [3:0] FW_CODE_COUNT = 4'd9;
  localparam logic [3:0] FW_DEFAULT_SHIFT = 4'd4;   // code 119, 1024 us

  // field thresholds in mT, rising trip per code; falling is 6 mT lower
  localparam logic [7:0] FLAG_HYST_MT = 8'd6;
  localparam logic [7:0] FIELD_RISE_MT [8] = '{8'd26, 8'd41, 8'd56, 8'd70,
                                               8'd84, 8'd98, 8'd112, 8'd126};

endpackage

// File: sync_two_flop.sv
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop
  import abz_field_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic clk,       // destination clock
  input  wire logic rst,       // asynchronous, active high
  input  wire logic din,       // asynchronous level
  output logic      dout       // synchronised level
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // first stage feeds only the second one
  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= {RESET_VALUE, RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;

endmodule
`default_nettype wire

// File: field_flag.sv
`timescale 1ns/1ns
`default_nettype none
module field_flag
  import abz_field_pkg::*;
#(
  parameter logic HIGH_SIDE = 1'b1
) (
  input  wire logic       clk,        // system clock
  input  wire logic       rst,        // asynchronous, active high
  input  wire logic [7:0] field_mt,   // field strength in mT
  input  wire logic [2:0] code,       // threshold code
  output logic            flag        // registered alarm flag
);

  typedef struct packed {
    logic flag;
  } flag_state_t;

  flag_state_t st;
  flag_state_t next_st;
  logic [7:0]  rise_mt;
  logic [7:0]  fall_mt;

  // trip points 6 mT apart; each flag has its own threshold
  always_comb begin
    rise_mt = FIELD_RISE_MT[code];
    fall_mt = rise_mt - FLAG_HYST_MT;
    next_st = st;
    if (HIGH_SIDE) begin
      if (field_mt > rise_mt) begin
        next_st.flag = 1'b1;
      end else if (field_mt < fall_mt) begin
        next_st.flag = 1'b0;
      end
    end else begin
      if (field_mt < fall_mt) begin
        next_st.flag = 1'b1;
      end else if (field_mt > rise_mt) begin
        next_st.flag = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

endmodule
`default_nettype wire

// File: abz_encoder_field_flags.sv
// Notes on behaviour
// - low flag when field below low threshold, high flag above high threshold.
// - both flags switch with about 6 mT hysteresis.
// - two three-bit threshold codes share register 6.
// - code 000 trips 26/20 mT, code 111 trips 126/120 mT, about 14 mT steps.
// - low code may exceed high code; flags evaluated independently.
// - status reg 27 bit 7 high flag, bit 6 low flag; also on pins.
// - read frame 010, address, zeros; register returned in the next frame.
// - filter window codes 51..187 step 17 give 64..16384 us; 119 default.
// - 12-bit encoder emulation, B a quarter period from A.
// - A pulses per turn equal pulse count code plus one; four edges each.
// - pulse count low two bits in reg 4 bits 7:6, high eight in reg 5.
// - pulse count code resets to 1023.
// - index Z rises once per turn, at the zero angle when index shape bits 1:0 are 00.
// - index shape 0000: Z rises with B falling, half a pulse long.
// - 8-bit hysteresis code sets ABZ angular hysteresis; 156 default.
// - ABZ state recomputed at 16 MHz; at most one edge per update.
`timescale 1ns/1ns
`default_nettype none
module abz_encoder_field_flags
  import abz_field_pkg::*;
(
  input  wire logic        MCLK,            // 25 MHz clock
  input  wire logic        SYS_RST,         // asynchronous reset, active high
  input  wire logic [15:0] ANGLE,           // filtered absolute angle, full turn = 2^16
  input  wire logic [7:0]  FIELD_MT,        // field strength in mT
  input  wire logic        SCLK,            // SPI clock pin
  input  wire logic        CS_N,            // SPI chip select pin, active low
  input  wire logic        MOSI,            // SPI data in pin
  output logic             MISO,            // SPI data out
  output logic             MISO_OE,         // high while MISO is driven
  output logic             A_OUT,           // quadrature channel A
  output logic             B_OUT,           // quadrature channel B
  output logic             Z_OUT,           // index output
  output logic             FIELD_LOW_PIN,   // low field alarm pin
  output logic             FIELD_HIGH_PIN,  // high field alarm pin
  output logic [3:0]       FILTER_SHIFT     // filter time constant = 64 us << shift
);

  // block state apart from synchronisers and field flags in one register, advanced on every rising MCLK edge
  // ABZ levels live here too, so they leave from flip-flops
  // and cannot glitch while the edge index moves
  typedef struct packed {
    logic        sclk_d;
    logic        cs_n_d;
    logic [15:0] rx_sh;
    logic [15:0] tx_sh;
    logic [4:0]  bit_cnt;
    logic [15:0] tx_word;
    logic [7:0]  pulse_count_low_index_shape;
    logic [7:0]  pulse_count_high;
    logic [7:0]  field_threshold_config;
    logic [7:0]  filter_window_size;
    logic [7:0]  incremental_hysteresis;
    logic [3:0]  filter_shift;
    logic [4:0]  rate_acc;
    logic [11:0] edge_pos;
    logic        a;
    logic        b;
    logic        z;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  // synchronised pins, decoded configuration fields and the
  // combinational terms of the ABZ engine
  logic        sclk_s;
  logic        cs_n_s;
  logic        mosi_s;
  logic        field_low_flag;
  logic        field_high_flag;
  logic [9:0]  pulse_count_code;
  logic [3:0]  index_shape_select;
  logic [2:0]  low_field_threshold;
  logic [2:0]  high_field_threshold;
  logic [12:0] edges_per_rev;
  logic [15:0] hyst_angle;
  logic [11:0] pos_lag;
  logic [11:0] pos_lead;
  logic [12:0] ahead;
  logic [12:0] behind;
  logic [12:0] z_dist;
  logic [2:0]  z_len;
  logic [5:0]  acc_sum;
  logic        abz_tick;
  logic [15:0] rx_word;
  logic [7:0]  read_data;
  logic [4:0]  hit_addr;

  // SPI pins come from outside the clock domain
  // two flops keep metastability away from the decode; the cost is about
  // three MCLK of latency, so each SCLK phase must last four MCLK or more
  sync_two_flop #(.RESET_VALUE(1'b0)) u_sync_sclk (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .din  (SCLK),
    .dout (sclk_s)
  );

  sync_two_flop #(.RESET_VALUE(1'b1)) u_sync_cs (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .din  (CS_N),
    .dout (cs_n_s)
  );

  sync_two_flop #(.RESET_VALUE(1'b0)) u_sync_mosi (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .din  (MOSI),
    .dout (mosi_s)
  );

  // configuration fields
  // the pulse count code straddles two registers
  assign pulse_count_code     = {st.pulse_count_high,
                                 st.pulse_count_low_index_shape[PCL_POS +: 2]};
  assign index_shape_select   = st.pulse_count_low_index_shape[SHAPE_POS +: 4];
  assign low_field_threshold  = st.field_threshold_config[LOWTH_POS +: 3];
  assign high_field_threshold = st.field_threshold_config[HIGHTH_POS +: 3];

  // separate instances, so a low code above the high code is fine
  // the field value comes from logic on MCLK, so no synchroniser;
  // each flag keeps its own hysteresis state
  field_flag #(.HIGH_SIDE(1'b0)) u_flag_low (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .field_mt (FIELD_MT),
    .code     (low_field_threshold),
    .flag     (field_low_flag)
  );

  field_flag #(.HIGH_SIDE(1'b1)) u_flag_high (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .field_mt (FIELD_MT),
    .code     (high_field_threshold),
    .flag     (field_high_flag)
  );

  // hysteresis code to angle, 2^16 per turn; unlisted codes use the default
  // falling back to the default keeps a mistyped code from
  // shrinking the window to zero, where noise would toggle A and B
  function automatic logic [15:0] hyst_lookup(input logic [7:0] code);
    case (code)
      8'hC8:   hyst_lookup = 16'h000F;   // 0.08 deg
      8'hBC:   hyst_lookup = 16'h0019;   // 0.14 deg
      8'h94:   hyst_lookup = 16'h0021;   // 0.18 deg
      8'h98:   hyst_lookup = 16'h0042;   // 0.36 deg
      8'h74:   hyst_lookup = 16'h007F;   // 0.70 deg
      8'h78:   hyst_lookup = 16'h00FF;   // 1.4 deg
      8'h7C:   hyst_lookup = 16'h017E;   // 2.1 deg
      8'h54:   hyst_lookup = 16'h01FE;   // 2.8 deg
      default: hyst_lookup = 16'h005F;   // 0.52 deg
    endcase
  endfunction

  // angle to edge index, 0 .. edges_per_rev-1
  // the full product is kept, so the index is an exact floor
  function automatic logic [11:0] angle_to_edge(input logic [15:0] ang, input logic [12:0] n);
    logic [28:0] prod;
    prod = ang * n;
    angle_to_edge = prod[27:16];
  endfunction

  // (x - y) modulo n, both operands below n
  // no divider needed: one conditional wrap is enough
  function automatic logic [12:0] mod_sub(input logic [12:0] x, input logic [12:0] y,
                                          input logic [12:0] n);
    if (x >= y) begin
      mod_sub = x - y;
    end else begin
      mod_sub = x + n - y;
    end
  endfunction

  // encoder geometry and hysteresis window
  // lagging and leading positions sit one hysteresis width either
  // side of the angle, so a reversal must cross the whole window
  always_comb begin
    edges_per_rev = 13'({3'b000, pulse_count_code} + 13'd1) << 2;
    hyst_angle    = hyst_lookup(st.incremental_hysteresis);
    pos_lag       = angle_to_edge(ANGLE - hyst_angle, edges_per_rev);
    pos_lead      = angle_to_edge(ANGLE + hyst_angle, edges_per_rev);
    ahead         = mod_sub({1'b0, pos_lag}, {1'b0, st.edge_pos}, edges_per_rev);
    behind        = mod_sub({1'b0, st.edge_pos}, {1'b0, pos_lead}, edges_per_rev);
    z_dist        = mod_sub({1'b0, st.edge_pos}, {11'd0, index_shape_select[1:0]},
                            edges_per_rev);
    // index length in quarter periods; 0000 gives half an A pulse
    case (index_shape_select[3:2])
      2'b00:   z_len = 3'd2;
      2'b01:   z_len = 3'd1;
      2'b10:   z_len = 3'd3;
      default: z_len = 3'd4;
    endcase
  end

  // 16 MHz update tick from 25 MHz by fractional accumulation
  // the average rate is exact, but ticks are irregular: one or two
  // MCLK apart; the sum stays below 41, so six bits suffice
  always_comb begin
    acc_sum  = {1'b0, st.rate_acc} + 6'(ABZ_UPDATE_MHZ);
    abz_tick = (acc_sum >= 6'(CLK_MHZ));
  end

  // register read mux; unmapped addresses read zero
  // the address comes from the shifter while the frame ends
  always_comb begin
    rx_word  = {st.rx_sh[14:0], mosi_s};
    hit_addr = st.rx_sh[12:8];
    case (hit_addr)
      ADDR_PULSE_LOW_INDEX: read_data = st.pulse_count_low_index_shape;
      ADDR_PULSE_HIGH:      read_data = st.pulse_count_high;
      ADDR_FIELD_THRESH:    read_data = st.field_threshold_config;
      ADDR_FILTER_WINDOW:   read_data = st.filter_window_size;
      ADDR_INCR_HYST:       read_data = st.incremental_hysteresis;
      ADDR_ALARM_STATUS:    read_data = {field_high_flag, field_low_flag, 6'd0};
      default:              read_data = 8'h00;
    endcase
  end

  // next state: SPI slave, register file, filter decode, ABZ engine
  // every field holds unless a branch updates it, so a slow
  // SPI frame and the ABZ engine never disturb each other
  always_comb begin
    next_st        = st;
    next_st.sclk_d = sclk_s;
    next_st.cs_n_d = cs_n_s;

    // frame start loads the answer prepared by the previous frame
    // MOSI is taken on the SCLK rise, MISO moves on the fall
    if (st.cs_n_d && !cs_n_s) begin
      next_st.bit_cnt = 5'd0;
      next_st.tx_sh   = st.tx_word;
    end else if (!cs_n_s) begin
      if (!st.sclk_d && sclk_s) begin
        next_st.rx_sh = rx_word;
        if (st.bit_cnt != SPI_FRAME_BITS) begin
          next_st.bit_cnt = st.bit_cnt + 5'd1;
        end
      end else if (st.sclk_d && !sclk_s) begin
        next_st.tx_sh = {st.tx_sh[14:0], 1'b0};
      end
    end

    // frame end: decode only full 16-bit frames
    // a cut frame is dropped and the next answer is zero; the count
    // stops at 16, so an overlong frame is decoded from its last 16 bits
    if (!st.cs_n_d && cs_n_s) begin
      next_st.tx_word = 16'h0000;
      if (st.bit_cnt == SPI_FRAME_BITS) begin
        if (st.rx_sh[15:13] == CMD_READ) begin
          next_st.tx_word = {read_data, 8'h00};
        end else if (st.rx_sh[15:13] == CMD_WRITE) begin
          case (hit_addr)
            ADDR_PULSE_LOW_INDEX: next_st.pulse_count_low_index_shape = st.rx_sh[7:0];
            ADDR_PULSE_HIGH:      next_st.pulse_count_high            = st.rx_sh[7:0];
            ADDR_FIELD_THRESH:    next_st.field_threshold_config      = st.rx_sh[7:0];
            ADDR_FILTER_WINDOW:   next_st.filter_window_size          = st.rx_sh[7:0];
            ADDR_INCR_HYST:       next_st.incremental_hysteresis      = st.rx_sh[7:0];
            default:              next_st.tx_word                     = 16'h0000;
          endcase
        end
      end
    end

    // only listed window codes change the time constant; others keep the last one
    // the filter never sees a time constant outside its table
    for (int k = 0; k < FW_CODE_COUNT; k++) begin
      if (st.filter_window_size == 8'(FW_FIRST_CODE + FW_CODE_STEP * k)) begin
        next_st.filter_shift = 4'(k);
      end
    end

    // one quarter-period step per update at most
    // a fast shaft may leave the index behind the angle; it
    // catches up one step per tick instead of jumping, so the
    // controller never sees A and B change together
    if (abz_tick) begin
      next_st.rate_acc = 5'(acc_sum - 6'(CLK_MHZ));
      if ({1'b0, st.edge_pos} >= edges_per_rev) begin
        next_st.edge_pos = 12'd0;                       // pulse count shrank
      end else if (ahead != 13'd0 && ahead < (edges_per_rev >> 1)) begin
        next_st.edge_pos = ({1'b0, st.edge_pos} + 13'd1 == edges_per_rev) ?
                           12'd0 : st.edge_pos + 12'd1;
      end else if (behind != 13'd0 && behind < (edges_per_rev >> 1)) begin
        next_st.edge_pos = (st.edge_pos == 12'd0) ?
                           12'(edges_per_rev - 13'd1) : st.edge_pos - 12'd1;
      end
    end else begin
      next_st.rate_acc = acc_sum[4:0];
    end

    // outputs follow the edge index; B lags A by a quarter period
    // Z uses the same index, so it moves in step with A and B
    case (st.edge_pos[1:0])
      2'b00:   {next_st.a, next_st.b} = 2'b00;
      2'b01:   {next_st.a, next_st.b} = 2'b10;
      2'b10:   {next_st.a, next_st.b} = 2'b11;
      default: {next_st.a, next_st.b} = 2'b01;
    endcase
    next_st.z = (z_dist < {10'd0, z_len});
  end

  // state register; reset loads configuration defaults and an
  // idle select, so no false frame start follows reset
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st                             <= '0;
      st.sclk_d                      <= 1'b0;
      st.cs_n_d                      <= 1'b1;
      st.pulse_count_low_index_shape <= RST_PULSE_LOW_INDEX;
      st.pulse_count_high            <= RST_PULSE_HIGH;
      st.field_threshold_config      <= RST_FIELD_THRESH;
      st.filter_window_size          <= RST_FILTER_WINDOW;
      st.incremental_hysteresis      <= RST_INCR_HYST;
      st.filter_shift                <= FW_DEFAULT_SHIFT;
    end else begin
      st <= next_st;
    end
  end

  // pins show the flag states continuously
  // MISO is driven only while the synchronised select is low
  assign FIELD_LOW_PIN  = field_low_flag;
  assign FIELD_HIGH_PIN = field_high_flag;
  assign MISO           = st.tx_sh[15];
  assign MISO_OE        = !st.cs_n_d;
  assign A_OUT          = st.a;
  assign B_OUT          = st.b;
  assign Z_OUT          = st.z;
  assign FILTER_SHIFT   = st.filter_shift;

endmodule
`default_nettype wire

// File: abz_flags_checker.sv
`timescale 1ns/1ns
`default_nettype none
module abz_flags_checker
  import abz_field_pkg::*;
(
  input wire logic       MCLK,            // system clock
  input wire logic       SYS_RST,         // asynchronous reset, active high
  input wire logic [7:0] FIELD_MT,        // field strength in mT
  input wire logic       CS_N,            // select pin
  input wire logic       MISO_OE,         // data out enable
  input wire logic       A_OUT,           // channel a
  input wire logic       B_OUT,           // channel b
  input wire logic       Z_OUT,           // index
  input wire logic       FIELD_LOW_PIN,   // low field alarm
  input wire logic       FIELD_HIGH_PIN,  // high field alarm
  input wire logic [3:0] FILTER_SHIFT     // filter time constant select
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // one edge per update tick, never both channels at once
  quad_one_edge_a: assert property (!($changed(A_OUT) && $changed(B_OUT)))
    else $error("channels a and b changed together");
  // beyond every threshold code the verdict no longer depends on the codes
  high_over_a: assert property (FIELD_MT > 8'h7E |=> FIELD_HIGH_PIN && !FIELD_LOW_PIN)
    else $error("strong field without high flag");
  low_under_a: assert property (FIELD_MT < 8'h14 |=> FIELD_LOW_PIN && !FIELD_HIGH_PIN)
    else $error("weak field without low flag");
  high_rise_a: assert property ($rose(FIELD_HIGH_PIN) |-> $past(FIELD_MT) > 8'h1A)
    else $error("high flag set below lowest trip");
  high_fall_a: assert property ($fell(FIELD_HIGH_PIN) |-> $past(FIELD_MT) < 8'h78)
    else $error("high flag cleared above highest release");
  low_rise_a: assert property ($rose(FIELD_LOW_PIN) |-> $past(FIELD_MT) < 8'h78)
    else $error("low flag set above highest trip");
  low_fall_a: assert property ($fell(FIELD_LOW_PIN) |-> $past(FIELD_MT) > 8'h1A)
    else $error("low flag cleared below lowest release");
  // select passes a two-flop synchroniser, so the driver follows a few cycles late
  oe_follow_a: assert property ($fell(CS_N) |-> ##[2:4] MISO_OE)
    else $error("data out not enabled after select");
  // default shape; the shifted shape in the bench rises from a0b0, which leaves this vacuous
  index_b_fall_a: assert property ($rose(Z_OUT) && $past(A_OUT || B_OUT) |-> $fell(B_OUT))
    else $error("index rose away from b falling");
  shift_range_a: assert property (FILTER_SHIFT <= 4'h8)
    else $error("filter shift out of range");
  shift_quiet_a: assert property ($changed(FILTER_SHIFT) |-> CS_N && $past(CS_N, 4))
    else $error("filter shift changed inside a frame");

  // main scenarios
  cover property ($rose(Z_OUT));
  cover property (FIELD_LOW_PIN && FIELD_HIGH_PIN);
  cover property ($changed(FILTER_SHIFT));
endmodule
`default_nettype wire

// File: abz_reader.sv
`timescale 1ns/1ns
`default_nettype none
module abz_reader (
  input  wire logic clk,  // system clock
  input  wire logic clr,  // clear counts
  input  wire logic a,    // channel a
  input  wire logic b,    // channel b
  input  wire logic z,    // index
  output int        pos,  // signed edge count
  output int        zc,   // index rises
  output int        bad   // illegal steps and index rises off b falling
);
  logic [1:0] pidx;
  logic [1:0] nidx;
  logic [1:0] step;
  logic       pz;
  logic       pb;

  // gray state to quarter index: 00,10,11,01 is forward
  assign nidx = {b, a ^ b};
  assign step = nidx - pidx;

  // a counter as a controller keeps it; a double step is lost position
  always @(posedge clk) begin
    pidx <= nidx;
    pz <= z;
    pb <= b;
    if (clr) begin
      pos <= 0;
      zc <= 0;
      bad <= 0;
    end else begin
      if (step == 2'd1) pos <= pos + 1;
      if (step == 2'd3) pos <= pos - 1;
      if (step == 2'd2) bad <= bad + 1;
      if (z && !pz) begin
        zc <= zc + 1;
        if (!(pb && !b)) bad <= bad + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import abz_field_pkg::*;
;
  logic        mclk = 1'b0;
  logic        sys_rst, sclk, cs_n, mosi, clr;
  logic [15:0] angle;
  logic [7:0]  field, d;
  logic        miso, miso_oe, a_o, b_o, z_o, f_low, f_high;
  logic [3:0]  fshift;
  int          pos, zc, bad;
  int          errors = 0;
  int          tests_run = 0;
  // field steps and expected {high,low}; codes swap at entry 9
  logic [7:0]  fv [12] = '{8'd30, 8'd21, 8'd19, 8'd25, 8'd27, 8'd125, 8'd127, 8'd121, 8'd119, 8'd100, 8'd130, 8'd19};
  logic [1:0]  fe [12] = '{2'b00, 2'b00, 2'b01, 2'b01, 2'b00, 2'b00, 2'b10, 2'b10, 2'b00, 2'b11, 2'b10, 2'b01};

  always #20 mclk = ~mclk;

  abz_encoder_field_flags DUT (.MCLK(mclk), .SYS_RST(sys_rst), .ANGLE(angle), .FIELD_MT(field), .SCLK(sclk),
    .CS_N(cs_n), .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .A_OUT(a_o), .B_OUT(b_o), .Z_OUT(z_o),
    .FIELD_LOW_PIN(f_low), .FIELD_HIGH_PIN(f_high), .FILTER_SHIFT(fshift));
  abz_reader reader (.clk(mclk), .clr(clr), .a(a_o), .b(b_o), .z(z_o), .pos(pos), .zc(zc), .bad(bad));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // slow edges: each clock phase lasts five cycles, above the synchroniser's need
  task automatic frame(input logic [2:0] cmd, input logic [4:0] addr, input logic [7:0] val,
                       output logic [15:0] rx);
    logic [15:0] tx;
    tx = {cmd, addr, val};
    cs_n <= 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      mosi <= tx[i];
      tick(5);
      sclk <= 1'b1;
      tick(5);
      rx[i] = miso;
      sclk <= 1'b0;
    end
    tick(5);
    cs_n <= 1'b1;
    tick(12);
  endtask

  // the answer arrives one frame late, so the read is sent twice
  task automatic rd(input logic [4:0] addr, output logic [7:0] v);
    logic [15:0] rx;
    frame(CMD_READ, addr, 8'h00, rx);
    frame(CMD_READ, addr, 8'h00, rx);
    v = rx[15:8];
  endtask

  task automatic wr(input logic [4:0] addr, input logic [7:0] v);
    logic [15:0] rx;
    frame(CMD_WRITE, addr, v, rx);
  endtask

  task automatic spin(input int dir, input int steps);
    repeat (steps) begin
      angle <= angle + 16'(dir * 256);
      tick(4);
    end
  endtask

  task automatic clear;
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    tick(1);
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    tick(60000);
    errors++;
    $display("mismatch at %0t: run too long", $time);
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    clr = 1'b1;
    angle = 16'h0000;
    field = 8'd60;
    tick(12);
    sys_rst <= 1'b0;
    clr <= 1'b0;
    tick(4);
    rd(ADDR_PULSE_LOW_INDEX, d); chk(d, 8'hC0, "reg 4 reset");
    rd(ADDR_PULSE_HIGH, d); chk(d, 8'hFF, "reg 5 reset");
    rd(ADDR_FIELD_THRESH, d); chk(d, RST_FIELD_THRESH, "reg 6 reset");
    rd(ADDR_INCR_HYST, d); chk(d, RST_INCR_HYST, "hysteresis reset");
    rd(ADDR_FILTER_WINDOW, d); chk(d, 8'd119, "filter reset");
    rd(5'h1F, d); chk(d, 8'h00, "unmapped read");
    chk({4'h0, fshift}, 8'h04, "filter shift reset");
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_FILTER_WINDOW, 8'(51 + 17 * i));
      chk({4'h0, fshift}, 8'(i), "filter shift");
    end
    wr(ADDR_FILTER_WINDOW, 8'd52);
    chk({4'h0, fshift}, 8'h08, "unlisted filter code");
    wr(ADDR_FILTER_WINDOW, 8'd119);
    $display("test filter done");
    wr(ADDR_ALARM_STATUS, 8'hFF);
    for (int i = 0; i < 12; i++) begin
      if (i == 9) wr(ADDR_FIELD_THRESH, 8'hE0);
      field <= fv[i];
      tick(2);
      chk({6'h00, f_high, f_low}, {6'h00, fe[i]}, "flag pins");
      rd(ADDR_ALARM_STATUS, d); chk({6'h00, d[7:6]}, {6'h00, fe[i]}, "status flags");
    end
    $display("test flags done");
    wr(ADDR_PULSE_LOW_INDEX, 8'h00);
    wr(ADDR_PULSE_HIGH, 8'h00);
    angle <= 16'h2000;
    tick(40);
    clear();
    spin(1, 256);
    chk(8'(pos), 8'h04, "edges forward"); chk(8'(zc), 8'h01, "index forward");
    spin(-1, 256);
    chk(8'(pos), 8'h00, "edges back"); chk(8'(zc), 8'h02, "index back");
    chk(8'(bad), 8'h00, "quadrature order");
    angle <= 16'd16584;
    tick(40);
    clear();
    angle <= 16'd16334;
    tick(40);
    chk(8'(pos), 8'h00, "inside hysteresis");
    angle <= 16'd16184;
    tick(40);
    chk(8'(pos), 8'hFF, "past hysteresis");
    wr(ADDR_INCR_HYST, 8'd200);
    angle <= 16'd16584;
    tick(40);
    clear();
    angle <= 16'd16334;
    tick(40);
    chk(8'(pos), 8'hFF, "narrow hysteresis");
    wr(ADDR_INCR_HYST, 8'd156);
    wr(ADDR_PULSE_LOW_INDEX, 8'hC0);
    tick(100);
    clear();
    spin(1, 256);
    chk(8'(pos), 8'h10, "edges code 3"); chk(8'(zc), 8'h01, "index code 3");
    chk(8'(bad), 8'h00, "quadrature code 3");
    // shape 0101: index a quarter later and a quarter long, so it rises with a
    wr(ADDR_PULSE_LOW_INDEX, 8'hC5);
    tick(100);
    clear();
    spin(1, 256);
    chk(8'(pos), 8'h10, "edges shifted index"); chk(8'(zc), 8'h01, "index shifted");
    chk(8'(bad), 8'h01, "index off b falling");
    $display("test encoder done");
    conclude();
  end
endmodule

bind abz_encoder_field_flags abz_flags_checker u_check (.MCLK(MCLK), .SYS_RST(SYS_RST), .FIELD_MT(FIELD_MT),
  .CS_N(CS_N), .MISO_OE(MISO_OE), .A_OUT(A_OUT), .B_OUT(B_OUT), .Z_OUT(Z_OUT), .FIELD_LOW_PIN(FIELD_LOW_PIN),
  .FIELD_HIGH_PIN(FIELD_HIGH_PIN), .FILTER_SHIFT(FILTER_SHIFT));
`default_nettype wire
